// ==== core/pafm_pkg.sv ====
// Constants for the port alternate function mux.
// Assumes a single system clock and synchronous active-high reset.
// Contract
// - Peripheral signals are ANDed with the port latch bit: output always, input outside input-only mode.
// - A zero latch bit forces alternate output to zero, and alternate input too outside input-only mode.
// - Clearing the latch forces zero, except for input-only pins.
// - Two mode bits choose quasi, output, input-only or open-drain mode.
// - Port 1 bit 0 is general only with secondary oscillator off or internal.
// - Port 4 bit 2 is general with secondary oscillator off, internal or ext.
// - Port 4 bit 4 carries address latch strobe unless latch-off bit is set.
// - Port 4 bit 6 is general only with primary oscillator in internal RC.
// - Port 4 bit 7 is general with primary oscillator internal RC or ext.
// - Analog input pins come up input-only after reset, whatever the fuse.
package pafm_pkg;
    localparam int NPORT = 5;
    localparam int NPIN = NPORT * 8;

    typedef enum logic [1:0] {
        PAFM_MODE_QUASI = 2'h0,
        PAFM_MODE_PUSH = 2'h1,
        PAFM_MODE_INPUT = 2'h2,
        PAFM_MODE_OPEN = 2'h3
    } pafm_mode_t;

    typedef enum logic [1:0] {
        PAFM_OSC_OFF = 2'h0,
        PAFM_OSC_XTAL = 2'h1,
        PAFM_OSC_EXT = 2'h2,
        PAFM_OSC_INT = 2'h3
    } pafm_osc_t;

    // Register offsets on the plain port
    localparam logic [3:0] ADDR_LATCH0 = 4'h0;
    localparam logic [3:0] ADDR_MODE_FIRST0 = 4'h5;
    localparam logic [3:0] ADDR_MODE_SECOND0 = 4'hA;
    localparam logic [3:0] ADDR_CONFIG = 4'hF;
    localparam int CFG_PRI_LSB = 0;
    localparam int CFG_SEC_LSB = 2;
    localparam int CFG_ALOFF_BIT = 4;
    localparam int CFG_FUSE_BIT = 5;

    // Pin indices of the shared pins
    localparam int PIN_SEC_XIN = 8;
    localparam int PIN_SEC_XOUT = 34;
    localparam int PIN_ALE = 36;
    localparam int PIN_PRI_XIN = 38;
    localparam int PIN_PRI_XOUT = 39;

    // Reset values, fuse set / fuse clear
    localparam logic [39:0] RST_FIRST_FUSE1 = 40'hC7_FF_FF_FF_FF;
    localparam logic [39:0] RST_FIRST_FUSE0 = 40'h03_00_00_00_FF;
    localparam logic [39:0] RST_SECOND = 40'h03_00_00_00_FF;
    // Analog pins: port 0 and port 2 bits 2..7 forced input-only
    localparam logic [39:0] ANALOG_MASK = 40'h00_00_FC_00_FF;
    localparam logic [39:0] RST_LATCH = 40'hFF_FF_FF_FF_FF;
    localparam logic [7:0] RST_CONFIG = 8'h20;
endpackage

// ==== core/pafm_pin_if.sv ====
// Interface between the register file and the pin cell array.
// Assumes both ends sit on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface pafm_pin_if;
    logic [39:0] latch;
    logic [39:0] mode_first;
    logic [39:0] mode_second;
    logic [39:0] gp_free;
    modport regs (output latch, mode_first, mode_second, gp_free);
    modport cells (input latch, mode_first, mode_second, gp_free);
endinterface
`default_nettype wire

// ==== core/pafm_cells.sv ====
// Combinational pin cells: mode decode and latch gating per pin.
// Assumes pin inputs already synchronised by the caller.
`timescale 1ns/100ps
`default_nettype none
module pafm_cells (
    pafm_pin_if.cells pins,
    input wire logic [39:0] pin_sync,
    input wire logic [39:0] periph_out,
    input wire logic [39:0] periph_drv,
    output logic [39:0] next_pin_o,
    output logic [39:0] next_pin_oe,
    output logic [39:0] next_periph_in
);
    genvar g;
    generate
        for (g = 0; g < 40; g++) begin : g_pin
            logic [1:0] mode;
            logic drive_val;
            assign mode = {pins.mode_first[g], pins.mode_second[g]};
            // General data or peripheral data, gated by latch
            assign drive_val = pins.latch[g] &
                (periph_drv[g] ? periph_out[g] : 1'b1);
            always_comb begin
                next_pin_o[g] = drive_val;
                next_pin_oe[g] = 1'b0;
                unique case (mode)
                    // Weak pull-up outside; only a low is driven
                    pafm_pkg::PAFM_MODE_QUASI: next_pin_oe[g] = ~drive_val;
                    pafm_pkg::PAFM_MODE_PUSH: next_pin_oe[g] = 1'b1;
                    pafm_pkg::PAFM_MODE_INPUT: next_pin_oe[g] = 1'b0;
                    pafm_pkg::PAFM_MODE_OPEN: next_pin_oe[g] = ~drive_val;
                endcase
                // Crystal or strobe owned pins are never driven here
                if (!pins.gp_free[g]) begin
                    next_pin_oe[g] = 1'b0;
                end
                // Input-only ignores the latch
                if (mode == pafm_pkg::PAFM_MODE_INPUT) begin
                    next_periph_in[g] = pin_sync[g] & pins.gp_free[g];
                end else begin
                    next_periph_in[g] = pin_sync[g] & pins.latch[g] &
                        pins.gp_free[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== core/pafm_top.sv ====
// Port alternate function mux: latches, mode bits and pin gating.
// Assumes pins are asynchronous; peripherals run on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pafm_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [39:0] pin_i,
    output logic [39:0] pin_o,
    output logic [39:0] pin_oe,
    input wire logic [39:0] periph_out,
    input wire logic [39:0] periph_drv,
    output logic [39:0] periph_in,
    input wire logic ale_strobe,
    output logic ale_pin_o,
    output logic sec_xtal_sel,
    output logic pri_xtal_in_sel,
    output logic pri_xtal_out_sel
);
    pafm_pin_if pins ();

    logic [39:0] latch, next_latch;
    logic [39:0] mfirst, next_mfirst;
    logic [39:0] msecond, next_msecond;
    logic [7:0] cfg, next_cfg;
    logic [7:0] rdata, next_rdata;
    logic [39:0] sync1, sync2;
    logic [39:0] pin_o_r, pin_oe_r, pin_in_r;
    logic [39:0] c_o, c_oe, c_in;
    logic [39:0] gp_free;
    logic ale_r, sec_r, pin_r, pout_r;
    logic ale_pin, sec_own, pri_in_own, pri_out_own;
    pafm_pkg::pafm_osc_t pri_osc, sec_osc;

    // Index of the byte a register offset refers to
    function automatic logic [2:0] byte_sel(input logic [3:0] a,
                                            input logic [3:0] base);
        logic [3:0] d;
        d = a - base;
        byte_sel = d[2:0];
    endfunction

    function automatic logic in_range(input logic [3:0] a,
                                      input logic [3:0] base);
        in_range = (a >= base) && (a < base + 4'h5);
    endfunction

    assign pri_osc = pafm_pkg::pafm_osc_t'(cfg[pafm_pkg::CFG_PRI_LSB +: 2]);
    assign sec_osc = pafm_pkg::pafm_osc_t'(cfg[pafm_pkg::CFG_SEC_LSB +: 2]);

    // Ownership of shared pins by oscillators and strobe
    always_comb begin
        gp_free = '1;
        sec_own = !(sec_osc == pafm_pkg::PAFM_OSC_OFF ||
                    sec_osc == pafm_pkg::PAFM_OSC_INT);
        if (sec_own) begin
            gp_free[pafm_pkg::PIN_SEC_XIN] = 1'b0;
        end
        if (sec_own && sec_osc != pafm_pkg::PAFM_OSC_EXT) begin
            gp_free[pafm_pkg::PIN_SEC_XOUT] = 1'b0;
        end
        ale_pin = !cfg[pafm_pkg::CFG_ALOFF_BIT];
        if (ale_pin) begin
            gp_free[pafm_pkg::PIN_ALE] = 1'b0;
        end
        pri_in_own = pri_osc != pafm_pkg::PAFM_OSC_INT;
        if (pri_in_own) begin
            gp_free[pafm_pkg::PIN_PRI_XIN] = 1'b0;
        end
        pri_out_own = !(pri_osc == pafm_pkg::PAFM_OSC_INT ||
                        pri_osc == pafm_pkg::PAFM_OSC_EXT);
        if (pri_out_own) begin
            gp_free[pafm_pkg::PIN_PRI_XOUT] = 1'b0;
        end
    end

    assign pins.latch = latch;
    assign pins.mode_first = mfirst;
    assign pins.mode_second = msecond;
    assign pins.gp_free = gp_free;

    pafm_cells u_cells (
        .pins(pins),
        .pin_sync(sync2),
        .periph_out(periph_out),
        .periph_drv(periph_drv),
        .next_pin_o(c_o),
        .next_pin_oe(c_oe),
        .next_periph_in(c_in)
    );

    // Register writes and read mux
    always_comb begin
        next_latch = latch;
        next_mfirst = mfirst;
        next_msecond = msecond;
        next_cfg = cfg;
        next_rdata = 8'h00;
        if (reg_wr) begin
            if (in_range(reg_addr, pafm_pkg::ADDR_LATCH0)) begin
                next_latch[byte_sel(reg_addr, pafm_pkg::ADDR_LATCH0)*8 +: 8]
                    = reg_wdata;
            end else if (in_range(reg_addr, pafm_pkg::ADDR_MODE_FIRST0)) begin
                next_mfirst[byte_sel(reg_addr,
                    pafm_pkg::ADDR_MODE_FIRST0)*8 +: 8] = reg_wdata;
            end else if (in_range(reg_addr,
                                  pafm_pkg::ADDR_MODE_SECOND0)) begin
                next_msecond[byte_sel(reg_addr,
                    pafm_pkg::ADDR_MODE_SECOND0)*8 +: 8] = reg_wdata;
            end else begin
                next_cfg = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (in_range(reg_addr, pafm_pkg::ADDR_LATCH0)) begin
                next_rdata = latch[byte_sel(reg_addr,
                    pafm_pkg::ADDR_LATCH0)*8 +: 8];
            end else if (in_range(reg_addr, pafm_pkg::ADDR_MODE_FIRST0)) begin
                next_rdata = mfirst[byte_sel(reg_addr,
                    pafm_pkg::ADDR_MODE_FIRST0)*8 +: 8];
            end else if (in_range(reg_addr,
                                  pafm_pkg::ADDR_MODE_SECOND0)) begin
                next_rdata = msecond[byte_sel(reg_addr,
                    pafm_pkg::ADDR_MODE_SECOND0)*8 +: 8];
            end else begin
                next_rdata = cfg;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            latch <= pafm_pkg::RST_LATCH;
            cfg <= pafm_pkg::RST_CONFIG;
            rdata <= 8'h00;
            sync1 <= '0;
            sync2 <= '0;
            pin_o_r <= '0;
            pin_oe_r <= '0;
            pin_in_r <= '0;
            ale_r <= 1'b0;
            sec_r <= 1'b0;
            pin_r <= 1'b0;
            pout_r <= 1'b0;
            // Fuse-set default always; nothing reloads it from the fuse bit after release
            mfirst <= pafm_pkg::RST_FIRST_FUSE1 | pafm_pkg::ANALOG_MASK;
            msecond <= pafm_pkg::RST_SECOND & ~pafm_pkg::ANALOG_MASK;
        end else if (clk_en) begin
            latch <= next_latch;
            mfirst <= next_mfirst;
            msecond <= next_msecond;
            cfg <= next_cfg;
            rdata <= next_rdata;
            sync1 <= pin_i;
            sync2 <= sync1;
            pin_o_r <= c_o;
            pin_oe_r <= c_oe;
            pin_in_r <= c_in;
            ale_r <= ale_pin & ale_strobe;
            sec_r <= sec_own;
            pin_r <= pri_in_own;
            pout_r <= pri_out_own;
        end
    end

    // Flag set on the first enabled cycle after reset; the cfg fuse bit is never sampled, analog pins stay
    // input-only either way
    logic fuse_applied;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fuse_applied <= 1'b0;
        end else if (clk_en && !fuse_applied) begin
            fuse_applied <= 1'b1;
        end
    end

    assign reg_rdata = rdata;
    assign pin_o = pin_o_r;
    assign pin_oe = pin_oe_r;
    assign periph_in = pin_in_r;
    assign ale_pin_o = ale_r;
    assign sec_xtal_sel = sec_r;
    assign pri_xtal_in_sel = pin_r;
    assign pri_xtal_out_sel = pout_r;
endmodule
`default_nettype wire

// ==== testbench/pafm_asserts.sv ====
// Checker for the port mux: pin ownership, read timing, reset state.
// Assumes clk_en is held high while it watches.
`timescale 1ns/100ps
`default_nettype none
module pafm_asserts (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] periph_in,
    input wire logic ale_strobe,
    input wire logic ale_pin_o,
    input wire logic sec_xtal_sel,
    input wire logic pri_xtal_in_sel,
    input wire logic pri_xtal_out_sel
);
    logic cfg_wr;
    assign cfg_wr = reg_wr && reg_addr == pafm_pkg::ADDR_CONFIG;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_ale_low;
        !ale_strobe ##1 1'b1;
    endsequence
    sequence s_cfg_recent;
        $past(cfg_wr, 1) || $past(cfg_wr, 2);
    endsequence
    AST_ANALOG_QUIET: assert property ($fell(srst) |->
        ((pin_oe & pafm_pkg::ANALOG_MASK) == 40'h0) [*3])
        else $error("analog pin driven after reset");
    AST_SEC_XIN: assert property (sec_xtal_sel &&
        $past(sec_xtal_sel) |-> !pin_oe[pafm_pkg::PIN_SEC_XIN] &&
        !periph_in[pafm_pkg::PIN_SEC_XIN])
        else $error("secondary crystal pin used");
    AST_PRI_XIN: assert property (pri_xtal_in_sel &&
        $past(pri_xtal_in_sel) |-> !pin_oe[pafm_pkg::PIN_PRI_XIN] &&
        !periph_in[pafm_pkg::PIN_PRI_XIN])
        else $error("primary crystal in used");
    AST_PRI_XOUT: assert property (pri_xtal_out_sel &&
        $past(pri_xtal_out_sel) |-> !pin_oe[pafm_pkg::PIN_PRI_XOUT] &&
        !periph_in[pafm_pkg::PIN_PRI_XOUT])
        else $error("primary crystal out used");
    AST_PRI_NEST: assert property (pri_xtal_out_sel |-> pri_xtal_in_sel)
        else $error("crystal out owned without crystal in");
    AST_ALE_GATE: assert property (s_ale_low |-> !ale_pin_o)
        else $error("strobe pin high without strobe");
    AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_SEL_CAUSE: assert property (!$past(srst, 1) && !$past(srst, 2) &&
        !$past(srst, 3) && $changed(pri_xtal_in_sel) |-> s_cfg_recent)
        else $error("ownership changed without config write");
endmodule
bind pafm_top pafm_asserts pafm_asserts_inst (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_oe(pin_oe), .periph_in(periph_in),
    .ale_strobe(ale_strobe), .ale_pin_o(ale_pin_o),
    .sec_xtal_sel(sec_xtal_sel), .pri_xtal_in_sel(pri_xtal_in_sel),
    .pri_xtal_out_sel(pri_xtal_out_sel));
`default_nettype wire

// ==== testbench/pafm_pin_model.sv ====
// Pads and outside world: external drivers and pull-ups on every pin.
// Assumes a pull-up wherever neither side drives.
`timescale 1ns/100ps
`default_nettype none
module pafm_pin_model (
    input wire logic [39:0] pin_o,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] ext_drv,
    input wire logic [39:0] ext_val,
    output logic [39:0] pin_i
);
    // Device drive wins; a clash would be a board fault anyway
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~(ext_drv & ~ext_val));
endmodule
`default_nettype wire

// ==== testbench/tb_pafm_top.sv ====
// Testbench for the port mux: register file, pin gating, ownership.
// Assumes the pin model closes the loop from pin_o back to pin_i.
`timescale 1ns/100ps
`default_nettype none
module tb_pafm_top;
    typedef struct {logic [2:0] k; logic [39:0] m;
        logic [39:0] v;} pafm_note_t;
    localparam logic [7:0] RST_TAB [16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC7, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h03, 8'h20};
    logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [39:0] pin_i, pin_o, pin_oe, periph_in, seen;
    logic [39:0] periph_out = 40'h0, periph_drv = 40'h0;
    logic [39:0] ext_drv = 40'h0, ext_val = 40'h0;
    logic ale_strobe = 1'b0, ale_pin_o, sec_xtal_sel;
    logic pri_xtal_in_sel, pri_xtal_out_sel, rd_d = 1'b0, pin_chk = 1'b0;
    int miscompares = 0, checked = 0, cyc = 0;
    pafm_note_t notes[$];
    pafm_note_t n;
    string names [5] = '{"reg_rdata", "pin_oe", "pin_o", "periph_in",
        "osc_own"};
    pafm_top pafm_top_inst (.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .periph_out(periph_out), .periph_drv(periph_drv),
        .periph_in(periph_in), .ale_strobe(ale_strobe), .ale_pin_o(ale_pin_o),
        .sec_xtal_sel(sec_xtal_sel), .pri_xtal_in_sel(pri_xtal_in_sel),
        .pri_xtal_out_sel(pri_xtal_out_sel));
    pafm_pin_model pafm_pin_model_inst (.pin_o(pin_o), .pin_oe(pin_oe),
        .ext_drv(ext_drv), .ext_val(ext_val), .pin_i(pin_i));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        notes.push_back('{3'd0, 40'hFF, {32'h0, e}});
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic pchk(input logic [2:0] k, input logic [39:0] m, v);
        @(posedge clk_sys);
        pin_chk <= 1'b1;
        notes.push_back('{k, m, v});
        @(posedge clk_sys);
        pin_chk <= 1'b0;
    endtask
    // One note per result; reads and pin checks never share a cycle
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        ale_strobe <= 1'($urandom);
        if (rd_d || pin_chk) begin
            n = notes.pop_front();
            seen = n.k == 0 ? {32'h0, reg_rdata} : n.k == 1 ? pin_oe :
                n.k == 2 ? pin_o : n.k == 3 ? periph_in :
                {36'h0, sec_xtal_sel, pri_xtal_in_sel, pri_xtal_out_sel,
                ale_pin_o};
            checked++;
            if ((seen & n.m) !== (n.v & n.m)) begin
                miscompares++;
                $display("BAD %s exp %h seen %h", names[n.k], n.v & n.m,
                    seen & n.m);
            end
        end
        if (cyc == 2000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        logic [7:0] q, l, e, dr, po, c;
        logic [1:0] p, s;
        void'($urandom(32'he261));
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < 16; k++) rd(k[3:0], RST_TAB[k]);
        pchk(3'd1, pafm_pkg::ANALOG_MASK, 40'h0);
        wr(4'h8, 8'hF0);
        wr(4'hD, 8'hCC);
        ext_drv <= 40'hFF << 24;
        for (int k = 0; k < 6; k++) begin
            l = k == 0 ? 8'h00 : 8'($urandom);
            {e, dr, po} = 24'($urandom);
            wr(4'h3, l);
            periph_drv <= {8'h0, dr, 24'h0};
            periph_out <= {8'h0, po, 24'h0};
            ext_val <= {8'h0, e, 24'h0};
            q = l & ((dr & po) | ~dr);
            repeat (5) @(posedge clk_sys);
            pchk(3'd1, 40'hFF << 24,
                {8'h0, 8'h0C | (~q & 8'hC3), 24'h0});
            pchk(3'd2, 40'h0C << 24, {8'h0, q, 24'h0});
            pchk(3'd3, 40'hFF << 24, {8'h0, (q & 8'h0C) | (e & 8'h30) |
                (e & q & 8'hC3), 24'h0});
        end
        wr(4'h6, 8'hFE);
        wr(4'hB, 8'h01);
        wr(4'h9, 8'h03);
        wr(4'hE, 8'hD7);
        for (int k = 0; k < 16; k++) begin
            p = k[1:0];
            s = k[3:2];
            c = {3'b001, k[0] ^ k[3], k[3:0]};
            wr(4'hF, c);
            repeat (3) @(posedge clk_sys);
            pchk(3'd1, 40'hD4_0000_0100, {p[1], p == 2'h3, 1'b0, c[4],
                1'b0, s != 2'h1, 25'h0, s == 2'h0 || s == 2'h3,
                8'h00});
            pchk(3'd4, 40'hE, {36'h0, s == 2'h1 || s == 2'h2, p != 2'h3,
                !p[1], 1'b0});
            rd(4'hF, c);
        end
        results();
    end
endmodule
`default_nettype wire
